// [rtl/pcor_pkg.sv]
`default_nettype none
package pcor_pkg;

	// register addresses on the primary interface
	localparam logic [7:0] ADDR_OFFSET_Y   = 8'h72;
	localparam logic [7:0] ADDR_OFFSET_Z   = 8'h73;
	localparam logic [7:0] ADDR_POWER_SAVE = 8'h7C;
	localparam logic [7:0] ADDR_SENSOR_EN  = 8'h7D;
	localparam logic [7:0] ADDR_COMMAND    = 8'h7E;

	// reset values and writable-bit masks
	localparam logic [7:0] RST_OFFSET      = 8'h00;
	localparam logic [7:0] RST_POWER_SAVE  = 8'h03;
	localparam logic [7:0] RST_SENSOR_EN   = 8'h00;
	localparam logic [7:0] COMMAND_READ    = 8'h00;
	localparam logic [7:0] MASK_POWER_SAVE = 8'h03;
	localparam logic [7:0] MASK_SENSOR_EN  = 8'h05;

	// field positions
	localparam int BIT_ADV_POWER_SAVE = 0;
	localparam int BIT_FIFO_WAKEUP    = 1;
	localparam int BIT_AUX_EN         = 0;
	localparam int BIT_ACC_EN         = 2;

	// command codes
	localparam logic [7:0] CMD_NVM_PROG   = 8'hA0;
	localparam logic [7:0] CMD_FIFO_FLUSH = 8'hB0;
	localparam logic [7:0] CMD_SOFT_RESET = 8'hB6;

	// serial framing
	localparam logic [2:0] BIT_LAST   = 3'h7;
	localparam logic [7:0] SPI_DUMMY  = 8'h00;

	typedef enum logic [1:0] {
		PCOR_I2C_IDLE  = 2'b00,
		PCOR_I2C_ADDR  = 2'b01,
		PCOR_I2C_WRITE = 2'b10,
		PCOR_I2C_READ  = 2'b11
	} pcor_i2c_state_t;

endpackage : pcor_pkg
`default_nettype wire

// [rtl/pcor_top.sv]
`timescale 1ns/1ns
`default_nettype none

// Function
// [R1] Y offset byte at 0x72, NVM backed
// [R2] Z offset byte at 0x73, NVM backed
// [R3] offset enable adds offsets to data
// [R4] power config at 0x7C resets 0x03
// [R5] power save off keeps fast clock
// [R6] power save on: slow clock when idle
// [R7] FIFO reads gated by self-wakeup bit
// [R8] sensor enable at 0x7D resets 0x00
// [R9] bit2 accel enable, bit0 aux enable
// [R10] command port at 0x7E reads zero
// [R11] 0xA0 copies NVM-backed registers to NVM
// [R12] 0xB0 flushes FIFO, config kept
// [R13] 0xB6 soft reset restores defaults
// [R14] unknown command codes do nothing
// [R15] I2C slave after reset by default
// [R16] SPI four-wire, three-wire by software
// [R17] wire-mode bit: 0 four, 1 three
// [R18] chip-select rising edge latches SPI mode
// [R19] NV SPI-select bit forces SPI
// [R20] aux enable makes device sensor master
// [R21] shared data pin role per mode
// [R22] serial out pin: SERIAL_OUT_PIN, float, address
// [R23] chip select; tied high for I2C
// [R24] shared clock pin is SCK or SCL
// [R25] interrupt pins output or sync input
module pcor_top
	import pcor_pkg::*;
#(
	parameter logic [6:0] I2C_ADDR_BASE = 7'h10 // arbitrary default, low bit from strap
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        shared_clock_pin,
	input  wire logic        chip_select_n,
	input  wire logic        shared_data_pin_i,
	output logic             shared_data_pin_o,
	output logic             shared_data_pin_oe,
	input  wire logic        serial_out_pin_i,
	output logic             serial_out_pin_o,
	output logic             serial_out_pin_oe,
	input  wire logic        irq_pin_a_i,
	output logic             irq_pin_a_o,
	output logic             irq_pin_a_oe,
	input  wire logic        irq_pin_b_i,
	output logic             irq_pin_b_o,
	output logic             irq_pin_b_oe,
	input  wire logic        threeWireSelect,
	input  wire logic        spiEnableNv,
	input  wire logic        offsetApply,
	input  wire logic        measurementBusy,
	input  wire logic        fifoInterrupt,
	input  wire logic        fifoReadDone,
	input  wire logic        irqAIsInput,
	input  wire logic        irqBIsInput,
	input  wire logic        irqALevel,
	input  wire logic        irqBLevel,
	input  wire logic [15:0] accelYRaw,
	input  wire logic [15:0] accelZRaw,
	input  wire logic [15:0] accelYFilt,
	input  wire logic [15:0] accelZFilt,
	output logic [15:0]      accelYRawOut,
	output logic [15:0]      accelZRawOut,
	output logic [15:0]      accelYFiltOut,
	output logic [15:0]      accelZFiltOut,
	output logic [7:0]       offsetY,
	output logic [7:0]       offsetZ,
	output logic [7:0]       nvmOffsetY,
	output logic [7:0]       nvmOffsetZ,
	output logic             fastClockEnable,
	output logic             fifoReadAllow,
	output logic             accelEnable,
	output logic             auxMasterEnable,
	output logic             nvmProgramPulse,
	output logic             fifoFlushPulse,
	output logic             softResetPulse,
	output logic             spiMode,
	output logic             fifoSyncA,
	output logic             fifoSyncB
);

	logic        rstMeta;
	logic        rstSyncN;
	logic [5:0]  pinMeta;
	logic [5:0]  pinSync;
	logic [5:0]  pinLast;
	logic [7:0]  offYReg, offZReg, pwrReg, enReg, nvmYReg, nvmZReg;
	logic        spiLatchReg, wakeReg;
	logic        nvmProgReg, flushReg, softRstReg;
	logic        wrStrobeReg;
	logic [7:0]  wrAddrReg, wrDataReg;
	logic [2:0]  bitCntReg;
	logic [7:0]  rxShiftReg, txShiftReg, curAddrReg;
	logic        dataPhaseReg, isReadReg, txFreshReg;
	logic        ackPhaseReg, ackDriveReg, firstDataReg, masterNackReg;
	pcor_i2c_state_t i2cStateReg;
	logic [15:0] yRawReg, zRawReg, yFiltReg, zFiltReg;

	// offset is a signed byte, sign-extended onto the sample
	function automatic logic [15:0] addOffset(input logic [15:0] d, input logic [7:0] o,
		input logic en);
		addOffset = en ? 16'(d + {{8{o[7]}}, o}) : d;
	endfunction : addOffset

	// command port always reads back zero
	function automatic logic [7:0] regRead(input logic [7:0] a);
		case (a)
			ADDR_OFFSET_Y:   regRead = offYReg;
			ADDR_OFFSET_Z:   regRead = offZReg;
			ADDR_POWER_SAVE: regRead = pwrReg;
			ADDR_SENSOR_EN:  regRead = enReg;
			default:         regRead = COMMAND_READ; // [R10]
		endcase
	endfunction : regRead

	// reset release through two flops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta  <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstMeta  <= 1'b1;
			rstSyncN <= rstMeta;
		end
	end

	// pins are asynchronous: two flops, then a third copy for edges
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta <= 6'h3F;
			pinSync <= 6'h3F;
			pinLast <= 6'h3F;
		end else begin
			pinMeta <= {irq_pin_b_i, irq_pin_a_i, serial_out_pin_i, shared_data_pin_i,
				chip_select_n, shared_clock_pin};
			pinSync <= pinMeta;
			pinLast <= pinSync;
		end
	end

	// edges of the synchronised pins; SCK must stay below about 8 MHz at this rate
	wire sclIn   = pinSync[0];
	wire sdaIn   = pinSync[2];
	wire sclRise = pinSync[0] & ~pinLast[0];
	wire sclFall = ~pinSync[0] & pinLast[0];
	wire csRise  = pinSync[1] & ~pinLast[1];
	wire sdaRise = pinSync[2] & ~pinLast[2];
	wire sdaFall = ~pinSync[2] & pinLast[2];
	wire addrSel = pinSync[3]; // strap level on the serial out pin
	wire i2cStart = sdaFall & sclIn;
	wire i2cStop  = sdaRise & sclIn;
	wire spiActive = spiMode & ~pinSync[1]; // [R23]

	// command decode from the shared write path
	wire cmdHit    = wrStrobeReg & (wrAddrReg == ADDR_COMMAND);
	wire nvmNext   = cmdHit & (wrDataReg == CMD_NVM_PROG);
	wire flushNext = cmdHit & (wrDataReg == CMD_FIFO_FLUSH);
	wire softNext  = cmdHit & (wrDataReg == CMD_SOFT_RESET); // others ignored [R14]

	// configuration registers; soft reset restores them but keeps NVM
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			offYReg <= RST_OFFSET;
			offZReg <= RST_OFFSET;
			pwrReg  <= RST_POWER_SAVE;
			enReg   <= RST_SENSOR_EN;
		end else if (!rstSyncN || softRstReg) begin // [R13]
			offYReg <= RST_OFFSET;
			offZReg <= RST_OFFSET;
			pwrReg  <= RST_POWER_SAVE; // [R4]
			enReg   <= RST_SENSOR_EN; // [R8]
		end else if (wrStrobeReg) begin
			case (wrAddrReg)
				ADDR_OFFSET_Y:   offYReg <= wrDataReg; // [R1]
				ADDR_OFFSET_Z:   offZReg <= wrDataReg; // [R2]
				ADDR_POWER_SAVE: pwrReg  <= wrDataReg & MASK_POWER_SAVE;
				ADDR_SENSOR_EN:  enReg   <= wrDataReg & MASK_SENSOR_EN; // [R9]
				default:         ;
			endcase
		end
	end

	// command pulses, NVM image, SPI latch and wakeup flag
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nvmProgReg  <= 1'b0;
			flushReg    <= 1'b0;
			softRstReg  <= 1'b0;
			nvmYReg     <= RST_OFFSET;
			nvmZReg     <= RST_OFFSET;
			spiLatchReg <= 1'b0;
			wakeReg     <= 1'b0;
		end else begin
			nvmProgReg <= nvmNext; // [R11]
			flushReg   <= flushNext; // [R12]
			softRstReg <= softNext; // [R13]
			if (nvmProgReg) begin
				nvmYReg <= offYReg; // [R11]
				nvmZReg <= offZReg;
			end
			// a pin edge landing on the soft reset cycle still wins
			if (csRise)
				spiLatchReg <= 1'b1; // [R18]
			else if (softRstReg)
				spiLatchReg <= 1'b0;
			if (fifoInterrupt)
				wakeReg <= 1'b1;
			else if (fifoReadDone || softRstReg)
				wakeReg <= 1'b0;
		end
	end

	// serial engine for both protocols; one set of shift registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bitCntReg     <= 3'h0;
			rxShiftReg    <= 8'h00;
			txShiftReg    <= 8'h00;
			curAddrReg    <= 8'h00;
			dataPhaseReg  <= 1'b0;
			isReadReg     <= 1'b0;
			txFreshReg    <= 1'b0;
			ackPhaseReg   <= 1'b0;
			ackDriveReg   <= 1'b0;
			firstDataReg  <= 1'b0;
			masterNackReg <= 1'b0;
			i2cStateReg   <= PCOR_I2C_IDLE;
			wrStrobeReg   <= 1'b0;
			wrAddrReg     <= 8'h00;
			wrDataReg     <= 8'h00;
		end else begin
			wrStrobeReg <= 1'b0;
			if (!rstSyncN || softRstReg) begin
				i2cStateReg  <= PCOR_I2C_IDLE;
				dataPhaseReg <= 1'b0;
				ackPhaseReg  <= 1'b0;
				ackDriveReg  <= 1'b0;
				bitCntReg    <= 3'h0;
			end else if (spiMode) begin // [R24]
				i2cStateReg <= PCOR_I2C_IDLE;
				ackDriveReg <= 1'b0;
				if (!spiActive) begin
					bitCntReg    <= 3'h0;
					dataPhaseReg <= 1'b0;
				end else if (sclRise) begin // sample on rising SCK, modes 00 and 11
					rxShiftReg <= {rxShiftReg[6:0], sdaIn}; // [R21]
					bitCntReg  <= 3'(bitCntReg + 3'h1);
					if (bitCntReg == BIT_LAST) begin
						txFreshReg <= 1'b1;
						if (!dataPhaseReg) begin
							// first byte: read flag and address; dummy byte follows
							isReadReg    <= rxShiftReg[6];
							curAddrReg   <= {1'b0, rxShiftReg[5:0], sdaIn};
							dataPhaseReg <= 1'b1;
							txShiftReg   <= SPI_DUMMY;
						end else begin
							curAddrReg <= 8'(curAddrReg + 8'h01);
							txShiftReg <= regRead(curAddrReg);
							if (!isReadReg) begin
								wrStrobeReg <= 1'b1;
								wrAddrReg   <= curAddrReg;
								wrDataReg   <= {rxShiftReg[6:0], sdaIn};
							end
						end
					end
				end else if (sclFall) begin // drive on falling SCK
					if (txFreshReg)
						txFreshReg <= 1'b0;
					else
						txShiftReg <= {txShiftReg[6:0], 1'b0};
				end
			end else if (i2cStart) begin // [R15]
				i2cStateReg <= PCOR_I2C_ADDR;
				bitCntReg   <= 3'h0;
				ackPhaseReg <= 1'b0;
				ackDriveReg <= 1'b0;
			end else if (i2cStop) begin
				i2cStateReg <= PCOR_I2C_IDLE;
				ackPhaseReg <= 1'b0;
				ackDriveReg <= 1'b0;
			end else if (i2cStateReg != PCOR_I2C_IDLE) begin
				if (sclRise) begin
					if (!ackPhaseReg && i2cStateReg != PCOR_I2C_READ)
						rxShiftReg <= {rxShiftReg[6:0], sdaIn};
					if (ackPhaseReg && i2cStateReg == PCOR_I2C_READ)
						masterNackReg <= sdaIn;
				end else if (sclFall && !ackPhaseReg) begin
					bitCntReg <= 3'(bitCntReg + 3'h1);
					if (i2cStateReg == PCOR_I2C_READ)
						txShiftReg <= {txShiftReg[6:0], 1'b0};
					if (bitCntReg == BIT_LAST) begin
						ackPhaseReg <= 1'b1;
						case (i2cStateReg)
							PCOR_I2C_ADDR: begin
								// address low bit follows the strap [R22]
								if (rxShiftReg[7:1] == {I2C_ADDR_BASE[6:1], addrSel}) begin
									ackDriveReg   <= 1'b1;
									masterNackReg <= 1'b0;
									firstDataReg  <= 1'b1;
									i2cStateReg   <= rxShiftReg[0] ? PCOR_I2C_READ
										: PCOR_I2C_WRITE;
								end else begin
									i2cStateReg <= PCOR_I2C_IDLE;
								end
							end
							PCOR_I2C_WRITE: begin
								ackDriveReg  <= 1'b1;
								firstDataReg <= 1'b0;
								if (firstDataReg) begin
									curAddrReg <= rxShiftReg;
								end else begin
									wrStrobeReg <= 1'b1;
									wrAddrReg   <= curAddrReg;
									wrDataReg   <= rxShiftReg;
									curAddrReg  <= 8'(curAddrReg + 8'h01);
								end
							end
							default: ackDriveReg <= 1'b0;
						endcase
					end
				end else if (sclFall) begin // end of the acknowledge bit
					ackPhaseReg <= 1'b0;
					ackDriveReg <= 1'b0;
					bitCntReg   <= 3'h0;
					if (i2cStateReg == PCOR_I2C_READ) begin
						if (masterNackReg) begin
							i2cStateReg <= PCOR_I2C_IDLE;
						end else begin
							txShiftReg <= regRead(curAddrReg);
							curAddrReg <= 8'(curAddrReg + 8'h01);
						end
					end
				end
			end
		end
	end

	// offset correction of filtered and unfiltered samples
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			yRawReg  <= 16'h0000;
			zRawReg  <= 16'h0000;
			yFiltReg <= 16'h0000;
			zFiltReg <= 16'h0000;
		end else begin
			yRawReg  <= addOffset(accelYRaw, offYReg, offsetApply); // [R3]
			zRawReg  <= addOffset(accelZRaw, offZReg, offsetApply);
			yFiltReg <= addOffset(accelYFilt, offYReg, offsetApply);
			zFiltReg <= addOffset(accelZFilt, offZReg, offsetApply);
		end
	end

	// mode and pin steering; open drain I2C pulls low only
	wire readDrive = spiActive & dataPhaseReg & isReadReg;
	wire i2cDrive  = (ackPhaseReg & ackDriveReg) | (i2cStateReg == PCOR_I2C_READ
		& ~ackPhaseReg & ~txShiftReg[7]);
	assign spiMode            = spiLatchReg | spiEnableNv; // [R19]
	assign shared_data_pin_o  = spiMode & txShiftReg[7];
	assign shared_data_pin_oe = spiMode ? (readDrive & threeWireSelect) : i2cDrive; // [R16]
	assign serial_out_pin_o   = txShiftReg[7];
	assign serial_out_pin_oe  = readDrive & ~threeWireSelect; // [R17]
	assign irq_pin_a_o        = irqALevel;
	assign irq_pin_a_oe       = ~irqAIsInput; // [R25]
	assign irq_pin_b_o        = irqBLevel;
	assign irq_pin_b_oe       = ~irqBIsInput;
	assign fifoSyncA          = pinSync[4] & irqAIsInput;
	assign fifoSyncB          = pinSync[5] & irqBIsInput;

	// power and enable outputs
	assign fastClockEnable = ~pwrReg[BIT_ADV_POWER_SAVE] | measurementBusy; // [R5] [R6]
	assign fifoReadAllow   = ~pwrReg[BIT_ADV_POWER_SAVE]
		| (pwrReg[BIT_FIFO_WAKEUP] & wakeReg); // [R7]
	assign accelEnable     = enReg[BIT_ACC_EN];
	assign auxMasterEnable = enReg[BIT_AUX_EN]; // [R20]
	assign offsetY         = offYReg;
	assign offsetZ         = offZReg;
	assign nvmOffsetY      = nvmYReg;
	assign nvmOffsetZ      = nvmZReg;
	assign nvmProgramPulse = nvmProgReg;
	assign fifoFlushPulse  = flushReg;
	assign softResetPulse  = softRstReg;
	assign accelYRawOut    = yRawReg;
	assign accelZRawOut    = zRawReg;
	assign accelYFiltOut   = yFiltReg;
	assign accelZFiltOut   = zFiltReg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstSyncN);

	property p_offset_y;
		wrStrobeReg && wrAddrReg == ADDR_OFFSET_Y && !softRstReg |=> offsetY == $past(wrDataReg);
	endproperty
	a_offset_y: assert property (p_offset_y) else $error("Y offset write lost"); // [R1]

	property p_offset_z;
		wrStrobeReg && wrAddrReg == ADDR_OFFSET_Z && !softRstReg |=> offsetZ == $past(wrDataReg);
	endproperty
	a_offset_z: assert property (p_offset_z) else $error("Z offset write lost"); // [R2]

	property p_soft_defaults;
		softNext |=> ##1 pwrReg == RST_POWER_SAVE && enReg == RST_SENSOR_EN && offsetY == 8'h00;
	endproperty
	a_soft_defaults: assert property (p_soft_defaults) else $error("soft reset missed"); // [R13]

	property p_fast_clock;
		!pwrReg[BIT_ADV_POWER_SAVE] |-> fastClockEnable;
	endproperty
	a_fast_clock: assert property (p_fast_clock) else $error("fast clock stopped"); // [R5]

	property p_slow_clock;
		pwrReg[BIT_ADV_POWER_SAVE] && !measurementBusy |-> !fastClockEnable;
	endproperty
	a_slow_clock: assert property (p_slow_clock) else $error("fast clock left on"); // [R6]

	property p_fifo_refused;
		pwrReg[BIT_ADV_POWER_SAVE] && !pwrReg[BIT_FIFO_WAKEUP] |-> !fifoReadAllow;
	endproperty
	a_fifo_refused: assert property (p_fifo_refused) else $error("FIFO read allowed"); // [R7]

	property p_enable_bits;
		wrStrobeReg && wrAddrReg == ADDR_SENSOR_EN && !softRstReg |=>
			accelEnable == $past(wrDataReg[BIT_ACC_EN]) && auxMasterEnable == $past(wrDataReg[0]);
	endproperty
	a_enable_bits: assert property (p_enable_bits) else $error("enable bits wrong"); // [R9]

	property p_nvm_copy;
		nvmNext |=> nvmProgramPulse ##1 nvmOffsetY == $past(offYReg);
	endproperty
	a_nvm_copy: assert property (p_nvm_copy) else $error("NVM copy wrong"); // [R11]

	property p_flush_keeps;
		flushNext |=> fifoFlushPulse && $stable(pwrReg) && $stable(enReg);
	endproperty
	a_flush_keeps: assert property (p_flush_keeps) else $error("flush side effect"); // [R12]

	property p_unknown_cmd;
		cmdHit && !nvmNext && !flushNext && !softNext |=>
			!nvmProgramPulse && !fifoFlushPulse && !softResetPulse;
	endproperty
	a_unknown_cmd: assert property (p_unknown_cmd) else $error("stray command acted"); // [R14]

	property p_spi_latch;
		csRise |=> spiMode;
	endproperty
	a_spi_latch: assert property (p_spi_latch) else $error("SPI not latched"); // [R18]

	property p_sdo_float;
		spiMode && threeWireSelect |-> !serial_out_pin_oe;
	endproperty
	a_sdo_float: assert property (p_sdo_float) else $error("SERIAL_OUT_PIN driven in 3-wire"); // [R22]

endmodule : pcor_top
`default_nettype wire

// [tb/pcor_spi_host.sv]
`timescale 1ns/1ns
`default_nettype none

// host-side serial master, mode 00 only (clock idles low between frames)
module pcor_spi_host #(
	parameter int HALF = 5 // sys_clk cycles per half period, keeps the pin slow enough to sync
) (
	input  wire logic sys_clk,
	input  wire logic threeWire,
	input  wire logic dataOut,
	input  wire logic dataOe,
	input  wire logic sdoOut,
	input  wire logic sdoOe,
	output logic      sck,
	output logic      csN,
	output logic      dataPin,
	output logic      sdoPin,
	output logic      sdoOeSeen
);
	logic hostBit;
	logic hostEn;

	// shared line: device drive wins, then host, else the bus pull-up
	assign dataPin = dataOe ? dataOut : (hostEn ? hostBit : 1'b1);
	// the address strap holds the output pin at ground when nobody drives it
	assign sdoPin = sdoOe ? sdoOut : 1'b0;

	initial begin
		sck = 1'b0;
		csN = 1'b1;
		hostBit = 1'b0;
		hostEn = 1'b0;
		sdoOeSeen = 1'b0;
	end

	// any drive of the output pin in three-wire use is remembered
	always @(posedge sys_clk) begin
		if (threeWire && sdoOe === 1'b1) begin
			sdoOeSeen <= 1'b1;
		end
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wait_clk

	task automatic frame_start;
		csN = 1'b0;
		wait_clk(HALF);
	endtask : frame_start

	// clock returns low before select rises, so the rise is a clean frame end
	task automatic frame_end;
		sck = 1'b0;
		hostEn = 1'b0;
		wait_clk(HALF);
		csN = 1'b1;
		wait_clk(4 * HALF);
	endtask : frame_end

	// data changes with the falling clock, the reply is taken at the rise
	task automatic xfer_byte(input logic [7:0] tx, input logic drive, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			hostBit = tx[i];
			hostEn = drive;
			wait_clk(HALF);
			rx[i] = threeWire ? dataPin : sdoPin;
			sck = 1'b1;
			wait_clk(HALF);
		end
	endtask : xfer_byte
endmodule : pcor_spi_host

`default_nettype wire

// [tb/power_command_offset_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module power_command_offset_regs_tb;
	import pcor_pkg::*;
	logic        sys_clk, rst_n, sck, csN, dataPin, dataO, dataOe, sdoPin, sdoO, sdoOe;
	logic        irqAO, irqAOe, irqBO, irqBOe, irqDrvA, irqDrvB, threeWire, spiNv;
	logic        offApply, busy, fifoInt, fifoDone, aIsIn, bIsIn, aLvl, bLvl, sdoOeSeen;
	logic [15:0] yRaw, zRaw, yFilt, zFilt, yRawO, zRawO, yFiltO, zFiltO;
	logic [7:0]  offY, offZ, nvmY, nvmZ, rx;
	logic        fastClk, fifoAllow, accEn, auxEn, nvmP, flushP, softP, spiMode, syncA, syncB;
	int          n_checks, n_mismatch, cntNvm, cntFlush, cntSoft;
	logic [7:0]  rdA [6] = '{ADDR_OFFSET_Y, ADDR_OFFSET_Z, ADDR_POWER_SAVE, ADDR_SENSOR_EN,
		ADDR_COMMAND, 8'h10};
	logic [7:0]  rdE [6] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
	logic [7:0]  enV [4] = '{8'hFF, 8'h04, 8'h01, 8'h00};

	pcor_top pcor_top_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .shared_clock_pin(sck), .chip_select_n(csN),
		.shared_data_pin_i(dataPin), .shared_data_pin_o(dataO), .shared_data_pin_oe(dataOe),
		.serial_out_pin_i(sdoPin), .serial_out_pin_o(sdoO), .serial_out_pin_oe(sdoOe),
		.irq_pin_a_i(irqAOe ? irqAO : irqDrvA), .irq_pin_a_o(irqAO), .irq_pin_a_oe(irqAOe),
		.irq_pin_b_i(irqBOe ? irqBO : irqDrvB), .irq_pin_b_o(irqBO), .irq_pin_b_oe(irqBOe),
		.threeWireSelect(threeWire), .spiEnableNv(spiNv), .offsetApply(offApply),
		.measurementBusy(busy), .fifoInterrupt(fifoInt), .fifoReadDone(fifoDone),
		.irqAIsInput(aIsIn), .irqBIsInput(bIsIn), .irqALevel(aLvl), .irqBLevel(bLvl),
		.accelYRaw(yRaw), .accelZRaw(zRaw), .accelYFilt(yFilt), .accelZFilt(zFilt),
		.accelYRawOut(yRawO), .accelZRawOut(zRawO), .accelYFiltOut(yFiltO),
		.accelZFiltOut(zFiltO), .offsetY(offY), .offsetZ(offZ), .nvmOffsetY(nvmY),
		.nvmOffsetZ(nvmZ), .fastClockEnable(fastClk), .fifoReadAllow(fifoAllow),
		.accelEnable(accEn), .auxMasterEnable(auxEn), .nvmProgramPulse(nvmP),
		.fifoFlushPulse(flushP), .softResetPulse(softP), .spiMode(spiMode),
		.fifoSyncA(syncA), .fifoSyncB(syncB));

	pcor_spi_host pcor_spi_host_inst (
		.sys_clk(sys_clk), .threeWire(threeWire), .dataOut(dataO), .dataOe(dataOe),
		.sdoOut(sdoO), .sdoOe(sdoOe), .sck(sck), .csN(csN), .dataPin(dataPin),
		.sdoPin(sdoPin), .sdoOeSeen(sdoOeSeen));

	// 50 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// command pulses are one cycle wide, so each is counted on its own edge
	always @(posedge sys_clk) begin
		if (nvmP === 1'b1) cntNvm++;
		if (flushP === 1'b1) cntFlush++;
		if (softP === 1'b1) cntSoft++;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wait_clk

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		pcor_spi_host_inst.frame_start();
		pcor_spi_host_inst.xfer_byte({1'b0, a[6:0]}, 1'b1, rx);
		pcor_spi_host_inst.xfer_byte(d, 1'b1, rx);
		pcor_spi_host_inst.frame_end();
	endtask : reg_write

	// first reply byte is a dummy and is dropped
	task automatic check_reg(input logic [7:0] a, input logic [7:0] e);
		pcor_spi_host_inst.frame_start();
		pcor_spi_host_inst.xfer_byte({1'b1, a[6:0]}, 1'b1, rx);
		pcor_spi_host_inst.xfer_byte(8'h00, ~threeWire, rx);
		pcor_spi_host_inst.xfer_byte(8'h00, ~threeWire, rx);
		pcor_spi_host_inst.frame_end();
		`CHK(rx, e)
	endtask : check_reg

	task automatic pulse_wake(input logic clr);
		if (clr) fifoDone = 1'b1;
		else fifoInt = 1'b1;
		wait_clk(1);
		fifoInt = 1'b0;
		fifoDone = 1'b0;
		wait_clk(2);
	endtask : pulse_wake

	function automatic logic [15:0] add_off(input logic [15:0] v, input logic [7:0] o);
		return v + {{8{o[7]}}, o};
	endfunction : add_off

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test

	// hang guard, well beyond the roughly 7400 cycles the sequence needs
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_mismatch++;
		stop_test();
	end

	initial begin
		{threeWire, spiNv, offApply, busy, fifoInt, fifoDone} = '0;
		{aIsIn, bIsIn, aLvl, bLvl, irqDrvA, irqDrvB} = '0;
		{yRaw, zRaw, yFilt, zFilt} = {16'h0100, 16'h7FF0, 16'hFF80, 16'h0000};
		rst_n = 1'b0;
		wait_clk(8);
		rst_n = 1'b1;
		wait_clk(6);
		`CHK(spiMode, 1'b0)
		pcor_spi_host_inst.frame_start();
		pcor_spi_host_inst.frame_end();
		`CHK(spiMode, 1'b1)
		for (int i = 0; i < 6; i++) check_reg(rdA[i], rdE[i]);
		`CHK({accEn, auxEn}, 2'b00)
		// burst write relies on the address stepping to the next register
		pcor_spi_host_inst.frame_start();
		pcor_spi_host_inst.xfer_byte({1'b0, ADDR_OFFSET_Y[6:0]}, 1'b1, rx);
		pcor_spi_host_inst.xfer_byte(8'hA5, 1'b1, rx);
		pcor_spi_host_inst.xfer_byte(8'h5A, 1'b1, rx);
		pcor_spi_host_inst.frame_end();
		check_reg(ADDR_OFFSET_Y, 8'hA5);
		check_reg(ADDR_OFFSET_Z, 8'h5A);
		`CHK({offY, offZ}, 16'hA55A)
		offApply = 1'b1;
		wait_clk(3);
		`CHK({yRawO, yFiltO}, {add_off(yRaw, 8'hA5), add_off(yFilt, 8'hA5)})
		`CHK({zRawO, zFiltO}, {add_off(zRaw, 8'h5A), add_off(zFilt, 8'h5A)})
		offApply = 1'b0;
		wait_clk(3);
		`CHK({yRawO, zFiltO}, {yRaw, zFilt})
		reg_write(ADDR_POWER_SAVE, 8'hFF);
		check_reg(ADDR_POWER_SAVE, 8'h03);
		`CHK({fastClk, fifoAllow}, 2'b00)
		busy = 1'b1;
		wait_clk(2);
		`CHK(fastClk, 1'b1)
		busy = 1'b0;
		pulse_wake(1'b0);
		`CHK(fifoAllow, 1'b1)
		pulse_wake(1'b1);
		`CHK(fifoAllow, 1'b0)
		reg_write(ADDR_POWER_SAVE, 8'h01);
		pulse_wake(1'b0);
		`CHK(fifoAllow, 1'b0)
		reg_write(ADDR_POWER_SAVE, 8'h00);
		`CHK({fastClk, fifoAllow}, 2'b11)
		for (int i = 0; i < 4; i++) begin
			reg_write(ADDR_SENSOR_EN, enV[i]);
			check_reg(ADDR_SENSOR_EN, enV[i] & 8'h05);
			`CHK({accEn, auxEn}, {enV[i][2], enV[i][0]})
		end
		reg_write(ADDR_COMMAND, CMD_NVM_PROG);
		`CHK({nvmY, nvmZ, cntNvm}, {16'hA55A, 32'd1})
		check_reg(ADDR_COMMAND, 8'h00);
		reg_write(ADDR_COMMAND, CMD_FIFO_FLUSH);
		`CHK({offY, offZ, cntFlush}, {16'hA55A, 32'd1})
		reg_write(ADDR_SENSOR_EN, 8'h05);
		reg_write(ADDR_COMMAND, 8'h55);
		`CHK(cntNvm + cntFlush + cntSoft, 2)
		`CHK({offY, offZ, accEn}, {16'hA55A, 1'b1})
		reg_write(ADDR_COMMAND, CMD_SOFT_RESET);
		`CHK(cntSoft, 1)
		`CHK({offY, offZ, accEn, nvmY}, {16'h0000, 1'b0, 8'hA5})
		check_reg(ADDR_POWER_SAVE, 8'h03);
		// a second power-on reset drops the serial mode chosen by the select edge
		rst_n = 1'b0;
		wait_clk(2);
		rst_n = 1'b1;
		wait_clk(6);
		`CHK(spiMode, 1'b0)
		spiNv = 1'b1;
		wait_clk(1);
		`CHK(spiMode, 1'b1)
		check_reg(ADDR_OFFSET_Y, 8'h00);
		threeWire = 1'b1;
		reg_write(ADDR_OFFSET_Z, 8'h3C);
		check_reg(ADDR_OFFSET_Z, 8'h3C);
		`CHK(sdoOeSeen, 1'b0)
		threeWire = 1'b0;
		aLvl = 1'b1;
		wait_clk(1);
		`CHK({irqAOe, irqAO, irqBOe, irqBO}, 4'b1110)
		{aIsIn, bIsIn, irqDrvA} = 3'b111;
		wait_clk(5);
		`CHK({irqAOe, irqBOe, syncA, syncB}, 4'b0010)
		irqDrvB = 1'b1;
		wait_clk(5);
		`CHK({syncA, syncB}, 2'b11)
		stop_test();
	end
endmodule : power_command_offset_regs_tb

`default_nettype wire
